// ===== rtl/fsc_defs.vh
// Register offsets, field positions and reset values of the configuration shadow block.
`ifndef FSC_DEFS_VH
`define FSC_DEFS_VH

// Register port geometry.
`define FSC_ADDR_W          9
`define FSC_DATA_W          16
`define FSC_MEM_DEPTH       304

// Static group registers.
`define FSC_ADDR_CLKGEN     9'h020
`define FSC_ADDR_CORE       9'h028
`define FSC_ADDR_AFE        9'h030
`define FSC_ADDR_BIAS_LO    9'h040
`define FSC_ADDR_BIAS_HI    9'h047
`define FSC_ADDR_PUMP       9'h048
`define FSC_ADDR_SERTX      9'h070

// Artefact-prone dynamic registers.
`define FSC_ADDR_SYNC_LO    9'h074
`define FSC_ADDR_SYNC_HI    9'h07e
`define FSC_ADDR_BLK_LO     9'h080
`define FSC_ADDR_BLK_HI     9'h081
`define FSC_ADDR_TEST_LO    9'h090
`define FSC_ADDR_TEST_HI    9'h096

// Frame-synchronised registers, then the window geometry words, which are forwarded at once.
`define FSC_ADDR_SEQ        9'h0c0
`define FSC_ADDR_WIN_ACT    9'h0c3
`define FSC_ADDR_BLK_LINES  9'h0c5
`define FSC_ADDR_MULT_TMR   9'h0c7
`define FSC_ADDR_FR_PERIOD  9'h0c8
`define FSC_ADDR_EXPOSURE   9'h0c9
`define FSC_ADDR_GAIN       9'h0cc
`define FSC_ADDR_FREEZE     9'h0ce
`define FSC_ADDR_STATUS     9'h0cf
`define FSC_ADDR_WIN_LO     9'h100
`define FSC_ADDR_WIN_HI     9'h12f

// Sequencer control fields.
`define FSC_SEQ_RUN         0
`define FSC_SEQ_MODE_LO     1
`define FSC_SEQ_MODE_HI     6
`define FSC_SEQ_TRIG        1
`define FSC_SEQ_SLAVE       2
`define FSC_SEQ_EXP_SYNC    3
`define FSC_SEQ_SUBSAMP     7
`define FSC_SEQ_BINNING     8

// Black-line fields.
`define FSC_BLK_LINES_HI    7
`define FSC_BLK_GATE_LO     8
`define FSC_BLK_GATE_HI     12

// Gain fields.
`define FSC_GAIN_AFE_HI     7
`define FSC_GAIN_MUX_LO     8
`define FSC_GAIN_MUX_HI     12
`define FSC_GAIN_LAT_COMP   13

// Freeze control fields.
`define FSC_FRZ_BLACK       0
`define FSC_FRZ_EXPOSURE    1
`define FSC_FRZ_GAIN        2
`define FSC_FRZ_ROI         3

// Reset values.
`define FSC_RST_WORD        16'h0000
`define FSC_RST_FREEZE      16'h000f

`endif

// ===== rtl/fsc_shadow.v
// One frame-synchronised shadow stage: pending copy, optional delay and active copy.
`timescale 1ns/10ps
module fsc_shadow #(
  parameter W = 16
) (
  // Clock and reset.
  input  wire         clock_i,
  input  wire         rstn_i,
  // Frame boundary and control.
  input  wire         frame_start_i,
  input  wire         sync_en_i,
  input  wire         delay_en_i,
  // Value written by the host.
  input  wire [W-1:0] wr_val_i,
  // Copy used by the sequencer.
  output reg  [W-1:0] active_o
);

  reg [W-1:0] stage_r;

  // At a frame boundary the written value is taken only when sync is enabled;
  // a frozen group keeps its stage, so writes made during the freeze land together.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage_r  <= {W{1'b0}};
      active_o <= {W{1'b0}};
    end else if (frame_start_i) begin
      if (sync_en_i) begin
        stage_r <= wr_val_i;
      end
      if (delay_en_i) begin
        active_o <= stage_r;
      end else if (sync_en_i) begin
        active_o <= wr_val_i;
      end
    end
  end

endmodule

// ===== rtl/fsc_top.v
// Configuration register bank with frame-synchronised active copies and group freezing.
`timescale 1ns/10ps
`include "fsc_defs.vh"
module fsc_top (
  // Clock and reset.
  input  wire        clock_i,
  input  wire        rstn_i,
  // Serial register port, word addressed.
  input  wire [8:0]  reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [15:0] reg_rdata_o,
  output reg         reg_rvalid_o,
  // Frame sequencer handshake.
  input  wire        frame_start_i,
  output reg         seq_run_o,
  output reg  [5:0]  seq_mode_o,
  output reg         blank_frame_o,
  // Immediate configuration stream to static and artefact-prone consumers.
  output reg         cfg_upd_o,
  output reg  [8:0]  cfg_addr_o,
  output reg  [15:0] cfg_data_o,
  // Active frame-synchronised settings, plus the gate first line, which follows writes at once.
  output wire [7:0]  act_black_lines_o,
  output reg  [4:0]  gate_first_line_o,
  output wire [15:0] act_mult_timer_o,
  output wire [15:0] act_frame_period_o,
  output wire [15:0] act_exposure_o,
  output wire [7:0]  act_afe_gain_o,
  output wire [4:0]  act_mux_gain_o,
  output wire [15:0] window_enable_mask_o,
  output wire        act_subsampling_o,
  output wire        act_binning_o
);

  integer i;

  // Register image of the whole map; the sequencer logic reads fixed words of it.
  reg  [15:0] cfg_mem [0:`FSC_MEM_DEPTH-1];

  // Named views of the written (not yet active) words.
  wire [15:0] seq_w;
  wire [15:0] win_w;
  wire [15:0] blk_w;
  wire [15:0] gain_w;
  wire [15:0] frz_w;
  wire [47:0] expo_w;
  wire [17:0] roi_w;

  // Per-group sync enables and latency selections.
  wire        sync_black;
  wire        sync_expo;
  wire        sync_gain;
  wire        sync_roi;
  wire        expo_delay;
  wire        gain_delay;

  // Active copies from the shadow stages.
  wire [7:0]  blk_act;
  wire [47:0] expo_act;
  wire [12:0] gain_act;
  wire [17:0] roi_act;

  // Decoded write and read targets.
  wire        addr_in_map;
  wire        wr_ok;
  wire        region_switch;
  wire        pending_any;
  reg  [15:0] rdata_nxt;
  reg         blank_nxt;

  assign seq_w  = cfg_mem[`FSC_ADDR_SEQ];
  assign win_w  = cfg_mem[`FSC_ADDR_WIN_ACT];
  assign blk_w  = cfg_mem[`FSC_ADDR_BLK_LINES];
  assign gain_w = cfg_mem[`FSC_ADDR_GAIN];
  assign frz_w  = cfg_mem[`FSC_ADDR_FREEZE];
  assign expo_w = {cfg_mem[`FSC_ADDR_EXPOSURE], cfg_mem[`FSC_ADDR_FR_PERIOD],
                   cfg_mem[`FSC_ADDR_MULT_TMR]};
  assign roi_w  = {seq_w[`FSC_SEQ_BINNING], seq_w[`FSC_SEQ_SUBSAMP], win_w};

  // Per-group sync enables from the freeze register.
  assign sync_black = frz_w[`FSC_FRZ_BLACK];
  assign sync_expo  = frz_w[`FSC_FRZ_EXPOSURE];
  assign sync_gain  = frz_w[`FSC_FRZ_GAIN];
  assign sync_roi   = frz_w[`FSC_FRZ_ROI];

  // Exposure is one frame late unless triggered master with exposure sync mode.
  assign expo_delay = ~(seq_w[`FSC_SEQ_TRIG] & ~seq_w[`FSC_SEQ_SLAVE] &
                        seq_w[`FSC_SEQ_EXP_SYNC]);
  // Gain latency compensation adds one frame to line up with exposure.
  assign gain_delay = gain_w[`FSC_GAIN_LAT_COMP];

  // Word decode: the status word is read only, the rest of the map is storage.
  assign addr_in_map = (reg_addr_i <= `FSC_ADDR_WIN_HI);  // Same 9-bit width on both sides.
  assign wr_ok       = reg_wr_i & addr_in_map & (reg_addr_i != `FSC_ADDR_STATUS);

  // Register writes land in the image one edge after the strobe; frame-related
  // words reach the sequencer through the shadow stages below, except the run, mode and gate fields.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (i = 0; i < `FSC_MEM_DEPTH; i = i + 1) begin
        cfg_mem[i] <= `FSC_RST_WORD;
      end
      cfg_mem[`FSC_ADDR_FREEZE] <= `FSC_RST_FREEZE;
    end else if (wr_ok) begin
      cfg_mem[reg_addr_i] <= reg_wdata_i;
    end
  end

  // Black-line count, frozen by its own sync bit.
  fsc_shadow #(
    .W (8)
  ) u_black (
    .clock_i       (clock_i),
    .rstn_i        (rstn_i),
    .frame_start_i (frame_start_i),
    .sync_en_i     (sync_black),
    .delay_en_i    (1'b0),
    .wr_val_i      (blk_w[`FSC_BLK_LINES_HI:0]),
    .active_o      (blk_act)
  );

  // Timer multiplier, frame period and exposure move as one set.
  fsc_shadow #(
    .W (48)
  ) u_expo (
    .clock_i       (clock_i),
    .rstn_i        (rstn_i),
    .frame_start_i (frame_start_i),
    .sync_en_i     (sync_expo),
    .delay_en_i    (expo_delay),
    .wr_val_i      (expo_w),
    .active_o      (expo_act)
  );

  // Column-multiplexer and front-end gains.
  fsc_shadow #(
    .W (13)
  ) u_gain (
    .clock_i       (clock_i),
    .rstn_i        (rstn_i),
    .frame_start_i (frame_start_i),
    .sync_en_i     (sync_gain),
    .delay_en_i    (gain_delay),
    .wr_val_i      (gain_w[`FSC_GAIN_MUX_HI:0]),
    .active_o      (gain_act)
  );

  // Window mask, subsampling and binning switch at the next frame start.
  fsc_shadow #(
    .W (18)
  ) u_roi (
    .clock_i       (clock_i),
    .rstn_i        (rstn_i),
    .frame_start_i (frame_start_i),
    .sync_en_i     (sync_roi),
    .delay_en_i    (1'b0),
    .wr_val_i      (roi_w),
    .active_o      (roi_act)
  );

  // Active settings driven straight from the shadow flip-flops.
  assign act_black_lines_o    = blk_act;
  assign act_mult_timer_o     = expo_act[15:0];
  assign act_frame_period_o   = expo_act[31:16];
  assign act_exposure_o       = expo_act[47:32];
  assign act_afe_gain_o       = gain_act[`FSC_GAIN_AFE_HI:0];
  assign act_mux_gain_o       = gain_act[`FSC_GAIN_MUX_HI:`FSC_GAIN_MUX_LO];
  assign window_enable_mask_o = roi_act[15:0];
  assign act_subsampling_o    = roi_act[16];
  assign act_binning_o        = roi_act[17];

  // A region switch is a different window selection or a subsampling/binning
  // change about to be taken; geometry edits of the active window never count.
  assign region_switch = sync_roi & (roi_w != roi_act);

  // Any frozen group with a written value that differs from its active copy.
  assign pending_any = (~sync_black & (blk_w[`FSC_BLK_LINES_HI:0] != blk_act)) |
                       (~sync_expo  & (expo_w != expo_act)) |
                       (~sync_gain  & (gain_w[`FSC_GAIN_MUX_HI:0] != gain_act)) |
                       (~sync_roi   & (roi_w != roi_act));

  // The frame that starts with a region switch carries training patterns only;
  // the flag holds until the next frame start, which clears it unless that frame also starts with a region switch.
  always @* begin
    blank_nxt = blank_frame_o;
    if (frame_start_i) begin
      blank_nxt = region_switch;
    end
  end

  // Sequencer run and mode bits act at once; the host keeps static settings
  // and reserved words steady while running, so no gating is done here.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seq_run_o         <= 1'b0;
      seq_mode_o        <= 6'h00;
      blank_frame_o     <= 1'b0;
      gate_first_line_o <= 5'h00;
    end else begin
      seq_run_o         <= seq_w[`FSC_SEQ_RUN];
      seq_mode_o        <= seq_w[`FSC_SEQ_MODE_HI:`FSC_SEQ_MODE_LO];
      blank_frame_o     <= blank_nxt;
      gate_first_line_o <= blk_w[`FSC_BLK_GATE_HI:`FSC_BLK_GATE_LO];
    end
  end

  // Every accepted write is forwarded at once. Black-level, sync-code,
  // test-pattern and window geometry consumers take it mid-frame without
  // stopping acquisition, so at most the current frame is affected.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_upd_o  <= 1'b0;
      cfg_addr_o <= 9'h000;
      cfg_data_o <= 16'h0000;
    end else begin
      cfg_upd_o <= wr_ok;
      if (wr_ok) begin
        cfg_addr_o <= reg_addr_i;
        cfg_data_o <= reg_wdata_i;
      end
    end
  end

  // Read mux: status word shows live block state, unmapped words read zero.
  always @* begin
    rdata_nxt = 16'h0000;
    if (reg_addr_i == `FSC_ADDR_STATUS) begin
      rdata_nxt = {10'h000, pending_any, gain_delay, expo_delay,
                   blank_frame_o, seq_run_o, 1'b0};
    end else if (addr_in_map) begin
      rdata_nxt = cfg_mem[reg_addr_i];
    end
  end

  // Read data are registered and valid for one cycle after the strobe.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_nxt;
      end
    end
  end

endmodule

// ===== testbench/fsc_host_model.sv
// Host model driving the register port and the frame boundary pulses.
`timescale 1ns/10ps
module fsc_host_model (
  // Clock.
  input  wire         clock_i,
  // Register port toward the block.
  output logic [8:0]  reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic        reg_wr_o,
  output logic        reg_rd_o,
  input  wire  [15:0] reg_rdata_i,
  input  wire         reg_rvalid_i,
  // Frame boundary pulse.
  output logic        frame_start_o
);
  initial {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o, frame_start_o} = '0;
  // One write; reserved words are never written, static words only with run low.
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clock_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
  // One read; the answer is taken one edge after the strobe.
  task automatic rd(input logic [8:0] a, output logic [15:0] d, output logic v);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clock_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
    v = reg_rvalid_i;
  endtask
  // One frame boundary, then one idle cycle to keep boundaries apart.
  task automatic frame();
    @(negedge clock_i);
    frame_start_o = 1'b1;
    @(negedge clock_i);
    frame_start_o = 1'b0;
    @(negedge clock_i);
  endtask
endmodule

// ===== testbench/fsc_top_sva.sv
// Concurrent checks on the ports of the configuration shadow block.
`timescale 1ns/10ps
module fsc_top_sva (
  // Clock and reset.
  input logic        clock_i,
  input logic        rstn_i,
  // Register port.
  input logic [8:0]  reg_addr_i,
  input logic [15:0] reg_wdata_i,
  input logic        reg_wr_i,
  // Frame sequencer and immediate stream.
  input logic        frame_start_i,
  input logic        blank_frame_o,
  input logic        cfg_upd_o,
  input logic [15:0] cfg_data_o,
  // Active copies.
  input logic [7:0]  act_black_lines_o,
  input logic [15:0] act_exposure_o,
  input logic [7:0]  act_afe_gain_o,
  input logic [15:0] window_enable_mask_o,
  input logic        act_subsampling_o,
  input logic        act_binning_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  logic roi_sync_r;
  // Mirror of the region sync bit, set after reset.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i)
      roi_sync_r <= 1'b1;
    else if (reg_wr_i && reg_addr_i == 9'h0ce)
      roi_sync_r <= reg_wdata_i[3];
  end
  sequence s_geom_wr;
    reg_wr_i && reg_addr_i >= 9'h100 && reg_addr_i <= 9'h12f;
  endsequence
  sequence s_roi_frozen;
    frame_start_i && !roi_sync_r;
  endsequence
  mask_hold_a: assert property (!frame_start_i |=> $stable(window_enable_mask_o))
    else $error("window mask changed between frame boundaries");
  black_hold_a: assert property (!frame_start_i |=> $stable(act_black_lines_o))
    else $error("black line count changed between frame boundaries");
  gain_hold_a: assert property (!frame_start_i |=> $stable(act_afe_gain_o))
    else $error("front-end gain changed between frame boundaries");
  exp_hold_a: assert property (!frame_start_i |=> $stable(act_exposure_o))
    else $error("exposure changed between frame boundaries");
  subbin_hold_a: assert property (!frame_start_i |=> $stable({act_subsampling_o, act_binning_o}))
    else $error("subsampling or binning changed between frame boundaries");
  blank_hold_a: assert property (!frame_start_i |=> $stable(blank_frame_o))
    else $error("blank flag changed inside a frame");
  roi_frozen_a: assert property (s_roi_frozen |=> $stable(window_enable_mask_o))
    else $error("window mask updated while region sync was off");
  geom_pass_a: assert property (s_geom_wr |=> cfg_upd_o && cfg_data_o == $past(reg_wdata_i))
    else $error("geometry write not passed on at once");
endmodule

bind fsc_top fsc_top_sva chk_i (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .frame_start_i(frame_start_i),
  .blank_frame_o(blank_frame_o), .cfg_upd_o(cfg_upd_o), .cfg_data_o(cfg_data_o),
  .act_black_lines_o(act_black_lines_o), .act_exposure_o(act_exposure_o),
  .act_afe_gain_o(act_afe_gain_o), .window_enable_mask_o(window_enable_mask_o),
  .act_subsampling_o(act_subsampling_o), .act_binning_o(act_binning_o));

// ===== testbench/fsc_top_tb.sv
// Self-checking bench for the configuration shadow block.
`timescale 1ns/10ps
module fsc_top_tb;
  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  wire  [8:0]  reg_addr_i, cfg_addr_o;
  wire  [15:0] reg_wdata_i, reg_rdata_o, cfg_data_o, act_mult_timer_o, act_frame_period_o;
  wire  [15:0] act_exposure_o, window_enable_mask_o;
  wire  [7:0]  act_black_lines_o, act_afe_gain_o;
  wire  [5:0]  seq_mode_o;
  wire  [4:0]  gate_first_line_o, act_mux_gain_o;
  wire         reg_wr_i, reg_rd_i, frame_start_i, reg_rvalid_o, seq_run_o, blank_frame_o;
  wire         cfg_upd_o, act_subsampling_o, act_binning_o;
  int          mismatches = 0;
  int          check_count = 0;
  logic [15:0] rd;
  logic        v;
  logic [8:0]  imm[4] = '{9'h074, 9'h090, 9'h080, 9'h105};
  always #2.5 clock_i = ~clock_i;
  fsc_host_model host (.clock_i(clock_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o), .frame_start_o(frame_start_i));
  fsc_top dut (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .frame_start_i(frame_start_i),
    .seq_run_o(seq_run_o), .seq_mode_o(seq_mode_o), .blank_frame_o(blank_frame_o),
    .cfg_upd_o(cfg_upd_o), .cfg_addr_o(cfg_addr_o), .cfg_data_o(cfg_data_o),
    .act_black_lines_o(act_black_lines_o), .gate_first_line_o(gate_first_line_o),
    .act_mult_timer_o(act_mult_timer_o), .act_frame_period_o(act_frame_period_o),
    .act_exposure_o(act_exposure_o), .act_afe_gain_o(act_afe_gain_o),
    .act_mux_gain_o(act_mux_gain_o), .window_enable_mask_o(window_enable_mask_o),
    .act_subsampling_o(act_subsampling_o), .act_binning_o(act_binning_o));
  // Compares one value and reports a difference at once.
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, exp, got);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Cuts a hang short at 4000 cycles, well beyond the hundred or so cycles the sequence needs.
  initial begin
    #20000;
    mismatches++;
    tally_and_finish();
  end
  // Main sequence: reset, then the update scenarios.
  initial begin
    repeat (5) @(posedge clock_i);
    @(negedge clock_i);
    rstn_i = 1'b1;
    host.rd(9'h0ce, rd, v);
    chk("freeze reset", rd, 16'h000f);
    // Region switch plus subsampling and binning waits for the boundary, then blanks.
    host.wr(9'h0c3, 16'h0002);
    host.wr(9'h0c0, 16'h0180);
    chk("mask early", window_enable_mask_o, 16'h0000);
    host.frame();
    chk("mask", window_enable_mask_o, 16'h0002);
    chk("sub bin", {act_subsampling_o, act_binning_o}, 2'b11);
    chk("blank", blank_frame_o, 1'b1);
    // Geometry, sync-code, test and black-level words pass at once.
    foreach (imm[i]) begin
      host.wr(imm[i], {7'h00, imm[i]});
      chk("cfg upd", cfg_upd_o, 1'b1);
      chk("cfg addr", cfg_addr_o, imm[i]);
      chk("cfg data", cfg_data_o, {7'h00, imm[i]});
    end
    host.frame();
    chk("no blank", blank_frame_o, 1'b0);
    // Gain at the next boundary, one boundary later with compensation on.
    host.wr(9'h0cc, 16'h0305);
    host.frame();
    chk("afe gain", act_afe_gain_o, 16'h0005);
    chk("mux gain", act_mux_gain_o, 16'h0003);
    host.wr(9'h0cc, 16'h2305);
    host.frame();
    host.frame();
    host.wr(9'h0cc, 16'h2407);
    host.frame();
    chk("gain late", act_afe_gain_o, 16'h0005);
    host.frame();
    chk("gain", act_afe_gain_o, 16'h0007);
    // Exposure one frame late, then immediate in triggered master sync mode.
    host.wr(9'h0c9, 16'h0123);
    host.frame();
    chk("exp late", act_exposure_o, 16'h0000);
    host.frame();
    chk("exp", act_exposure_o, 16'h0123);
    host.wr(9'h0c0, 16'h000a);
    host.wr(9'h0c0, 16'h000b);
    host.wr(9'h0c9, 16'h0456);
    chk("run", seq_run_o, 1'b1);
    chk("mode", seq_mode_o, 16'h0005);
    host.frame();
    chk("exp now", act_exposure_o, 16'h0456);
    chk("blank sub", blank_frame_o, 1'b1);
    chk("sub bin off", {act_subsampling_o, act_binning_o}, 2'b00);
    // Freeze exposure and gain across two frames, then release together.
    host.wr(9'h0ce, 16'h0009);
    host.wr(9'h0c9, 16'h0777);
    host.wr(9'h0cc, 16'h2409);
    host.frame();
    host.wr(9'h0c8, 16'h0050);
    host.wr(9'h0c7, 16'h0003);
    host.frame();
    chk("exp frozen", act_exposure_o, 16'h0456);
    chk("mult frozen", act_mult_timer_o, 16'h0000);
    chk("gain frozen", act_afe_gain_o, 16'h0007);
    // Status: pending frozen value, gain delay on, no exposure delay, run set.
    host.rd(9'h0cf, rd, v);
    chk("status", rd, 16'h0032);
    // The status word refuses writes, so nothing is forwarded.
    host.wr(9'h0cf, 16'hffff);
    chk("status wr", cfg_upd_o, 1'b0);
    host.wr(9'h0ce, 16'h000f);
    host.frame();
    chk("period", act_frame_period_o, 16'h0050);
    chk("mult", act_mult_timer_o, 16'h0003);
    chk("exp", act_exposure_o, 16'h0777);
    host.frame();
    chk("gain", act_afe_gain_o, 16'h0009);
    // Freeze black lines and region; the gate field still follows at once.
    host.wr(9'h0ce, 16'h0006);
    host.wr(9'h0c5, 16'h0a08);
    @(negedge clock_i);
    chk("gate line", gate_first_line_o, 16'h000a);
    host.wr(9'h0c3, 16'h8001);
    host.frame();
    chk("black frozen", act_black_lines_o, 16'h0000);
    chk("mask frozen", window_enable_mask_o, 16'h0002);
    host.wr(9'h0ce, 16'h000f);
    host.frame();
    chk("black", act_black_lines_o, 16'h0008);
    chk("mask", window_enable_mask_o, 16'h8001);
    // Unmapped word ignores writes and reads as zero.
    host.wr(9'h130, 16'h1234);
    chk("unmapped upd", cfg_upd_o, 1'b0);
    host.rd(9'h130, rd, v);
    chk("unmapped", rd, 16'h0000);
    chk("rvalid", v, 1'b1);
    tally_and_finish();
  end
endmodule
